// ---- src/vec_map_pkg.sv ----
package vec_map_pkg;

  // widths of the maskable side
  localparam int NUM_SRC = 15;  // vectored maskable sources
  localparam int NUM_REQ = 16;  // raw request lines (flash has two)
  localparam int SRC_W   = 4;

  typedef logic [15:0] vecAddr_t;

  // reset vectors, by reset priority
  localparam vecAddr_t VEC_RESET  = 16'hFFFE;
  localparam vecAddr_t VEC_CLKMON = 16'hFFFC;
  localparam vecAddr_t VEC_WDOG   = 16'hFFFA;
  localparam vecAddr_t VEC_IDLE   = 16'h0000;  // nothing pending

  // maskable vectors in default priority order, index 0 highest
  localparam vecAddr_t SRC_VEC [NUM_SRC] = '{
    16'hFFDE, 16'hFFDC, 16'hFFDA,  // timer ovf, pulse acc ovf, edge
    16'hFFB8,                      // flash command
    16'hFFB4, 16'hFFB2,            // rx buffer a / b done
    16'hFFB0, 16'hFFAE, 16'hFFAC,  // tx done, flow ctrl, mgmt done
    16'hFFAA, 16'hFFA8, 16'hFFA6,  // rx error, buf a / b overrun
    16'hFFA4, 16'hFFA2, 16'hFFA0   // babble, late coll, excess coll
  };

  // raw request bit positions that share the flash vector
  localparam int FLASH_DONE_BIT  = 3;
  localparam int FLASH_EMPTY_BIT = 4;

  // register offsets on the software port
  localparam logic [7:0] REG_EN_LO   = 8'h00;
  localparam logic [7:0] REG_EN_HI   = 8'h01;
  localparam logic [7:0] REG_PRIO    = 8'h02;
  localparam logic [7:0] REG_STAT_LO = 8'h03;
  localparam logic [7:0] REG_STAT_HI = 8'h04;
  localparam logic [7:0] REG_MASK_LO = 8'h05;
  localparam logic [7:0] REG_MASK_HI = 8'h06;
  localparam logic [7:0] REG_CAUSE   = 8'h07;
  localparam logic [7:0] REG_WINNER  = 8'h08;
  localparam int         TABLE_BIT   = 7;  // offsets 80..FF: handler table

  // reset values
  localparam logic [15:0] EN_RST   = 16'h0000;
  localparam logic [7:0]  PRIO_RST = 8'h00;
  localparam logic [14:0] STAT_RST = 15'h0000;
  localparam logic [14:0] MASK_RST = 15'h0000;
  localparam logic [4:0]  CAUSE_RST = 5'h00;

  // reset source group
  typedef struct packed {
    logic por;
    logic pin;
    logic lowVolt;
    logic clkMon;
    logic watchdog;
  } resetSrc_t;

  // software register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } regReq_t;

endpackage

// ---- src/vec_table_mem.sv ----
`timescale 1ns/1ps
// handler address table; the array has no reset so it keeps its contents
module vec_table_mem #(
  parameter int AW = 6
) (
  input  logic          core_clk,
  input  logic          rstn,
  input  logic [1:0]    we,
  input  logic [AW-1:0] waddr,
  input  logic [7:0]    wdata,
  input  logic [AW-1:0] raddr,
  output logic [15:0]   rdata_q
);

  logic [15:0] mem [2**AW];

  // byte lanes: lane 1 is the high byte (even address)
  always_ff @(posedge core_clk)
  begin
    if (we[1])
      mem[waddr][15:8] <= wdata;
    if (we[0])
      mem[waddr][7:0] <= wdata;
  end

  // registered read port
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 16'h0000;
    else
      rdata_q <= mem[raddr];
  end

endmodule

// ---- src/vector_and_reset_priority_map.sv ----
`timescale 1ns/1ps
// Functional notes
// - Timer overflow, pulse overflow and pulse edge go to FFDE, FFDC, FFDA, masked and enabled.
// - Receive buffer A and B done go to FFB4 and FFB2, masked and individually enabled.
// - Frame sent goes to FFB0, masked and gated by the transmit-done enable.
// - Pause flow control goes to FFAE, masked and gated by the flow-control enable.
// - Management transfer done goes to FFAC, masked and gated by its enable.
// - Receive error, buffer A overrun and buffer B overrun go to FFAA, FFA8, FFA6.
// - Babble, late collision and excess collision go to FFA4, FFA2, FFA0.
// - Writing a source's vector low byte to the elevate register makes it win.
// - Resets are vectored like interrupts, the handler coming from the table.
// - Power-on, pin and low voltage use FFFE, clock monitor FFFC, watchdog FFFA.
// - Any reset returns every control register to its start value; of the resets, only rstn clears the reset cause.
// - The handler table memory is never cleared by reset.
// - The low-voltage indication produces a system reset with the top vector.
// - Simultaneous requests resolve by fixed order, higher address first.
module vector_and_reset_priority_map (
  input  logic                    core_clk,
  input  logic                    rstn,
  input  vec_map_pkg::regReq_t    regReq,
  output logic [7:0]              rdData_q,
  input  logic [15:0]             rawReq,
  input  logic                    condCodeIBit,
  input  vec_map_pkg::resetSrc_t  resetSrc,
  input  logic                    coreRd,
  input  logic [15:0]             coreAddr,
  output logic [15:0]             coreData_q,
  output logic                    irqReq_q,
  output vec_map_pkg::vecAddr_t   coreVec_q,
  output logic                    sysReset_q,
  output logic                    intr_q
);

  import vec_map_pkg::*;

  logic [15:0]      en_q;
  logic [7:0]       prio_q;
  logic [14:0]      stat_q;
  logic [14:0]      mask_q;
  logic [4:0]       cause_q;
  vecAddr_t         rstVec_q;
  logic [NUM_SRC-1:0] srcPend;
  logic [SRC_W-1:0] winIdx;
  logic             winFound;
  logic             resetAny;
  logic             topReset;
  logic             wrHit;
  logic [1:0]       tblWe;
  vecAddr_t         rstVec_d;

  // collapse raw lines onto vectors; flash owns two raw lines
  function automatic logic [NUM_SRC-1:0] gateSrc(input logic [15:0] raw,
                                                 input logic [15:0] en);
    logic [15:0] g;
    logic [NUM_SRC-1:0] s;
    g = raw & en;
    s = '0;
    for (int b = 0; b < NUM_REQ; b++)
    begin
      if (b < FLASH_EMPTY_BIT)
        s[b] = s[b] | g[b];
      else if (b == FLASH_EMPTY_BIT)
        s[FLASH_DONE_BIT] = s[FLASH_DONE_BIT] | g[b];
      else
        s[b-1] = g[b];
    end
    return s;
  endfunction

  // low byte of a source's vector, which is also its elevate code
  function automatic logic [7:0] elevCode(input logic [SRC_W-1:0] idx);
    return SRC_VEC[idx][7:0];
  endfunction

  // local enable gating of every maskable source
  assign srcPend = gateSrc(rawReq, en_q);

  // any system reset source, and the shared top-priority group
  assign topReset = resetSrc.por | resetSrc.pin | resetSrc.lowVolt;
  assign resetAny = topReset | resetSrc.clkMon | resetSrc.watchdog;

  // reset vector by reset priority
  always_comb
  begin
    if (topReset)
      rstVec_d = VEC_RESET;
    else if (resetSrc.clkMon)
      rstVec_d = VEC_CLKMON;
    else if (resetSrc.watchdog)
      rstVec_d = VEC_WDOG;
    else
      rstVec_d = rstVec_q;
  end

  // fixed order first, then an elevated pending source overrides
  always_comb
  begin
    winIdx = '0;
    winFound = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (srcPend[i])
      begin
        winIdx = SRC_W'(i);
        winFound = 1'b1;
      end
    end
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (srcPend[i] && elevCode(SRC_W'(i)) == prio_q)
        winIdx = SRC_W'(i);
    end
  end

  // software write decode
  assign wrHit = regReq.wr && !regReq.addr[TABLE_BIT];

  // local enables; cleared again by any system reset
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      en_q <= EN_RST;
    else if (resetAny)
      en_q <= EN_RST;
    else if (wrHit && regReq.addr == REG_EN_LO)
      en_q[7:0] <= regReq.wdata;
    else if (wrHit && regReq.addr == REG_EN_HI)
      en_q[15:8] <= regReq.wdata;
  end

  // elevate register
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      prio_q <= PRIO_RST;
    else if (resetAny)
      prio_q <= PRIO_RST;
    else if (wrHit && regReq.addr == REG_PRIO)
      prio_q <= regReq.wdata;
  end

  // sticky per-vector status; a new request beats a same-cycle clear
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      stat_q <= STAT_RST;
    else if (resetAny)
      stat_q <= STAT_RST;
    else
    begin
      if (wrHit && regReq.addr == REG_STAT_LO)
        stat_q <= (stat_q & ~{7'h00, regReq.wdata}) | srcPend;
      else if (wrHit && regReq.addr == REG_STAT_HI)
        stat_q <= (stat_q & ~{regReq.wdata[6:0], 8'h00}) | srcPend;
      else
        stat_q <= stat_q | srcPend;
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      mask_q <= MASK_RST;
    else if (resetAny)
      mask_q <= MASK_RST;
    else if (wrHit && regReq.addr == REG_MASK_LO)
      mask_q[7:0] <= regReq.wdata;
    else if (wrHit && regReq.addr == REG_MASK_HI)
      mask_q[14:8] <= regReq.wdata[6:0];
  end

  // reset cause survives system resets so software can find out why
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cause_q <= CAUSE_RST;
    else if (wrHit && regReq.addr == REG_CAUSE)
      cause_q <= (cause_q & ~regReq.wdata[4:0]) | resetSrc;
    else
      cause_q <= cause_q | resetSrc;
  end

  // reset vector held after the source drops; the held value never reaches coreVec_q
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rstVec_q <= VEC_RESET;
    else
      rstVec_q <= rstVec_d;
  end

  // core-facing request, vector and reset
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irqReq_q <= 1'b0;
      coreVec_q <= VEC_RESET;
      sysReset_q <= 1'b0;
    end
    else
    begin
      irqReq_q <= winFound && !condCodeIBit && !resetAny;
      sysReset_q <= resetAny;
      if (resetAny)
        coreVec_q <= rstVec_d;
      else if (winFound)
        coreVec_q <= SRC_VEC[winIdx];
      else
        coreVec_q <= VEC_IDLE;
    end
  end

  // summary interrupt from unmasked sticky status
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      intr_q <= 1'b0;
    else
      intr_q <= |(stat_q & mask_q);
  end

  // software read port, data one cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rdData_q <= 8'h00;
    else if (regReq.rd)
    begin
      unique case (regReq.addr)
        REG_EN_LO:   rdData_q <= en_q[7:0];
        REG_EN_HI:   rdData_q <= en_q[15:8];
        REG_PRIO:    rdData_q <= prio_q;
        REG_STAT_LO: rdData_q <= stat_q[7:0];
        REG_STAT_HI: rdData_q <= {1'b0, stat_q[14:8]};
        REG_MASK_LO: rdData_q <= mask_q[7:0];
        REG_MASK_HI: rdData_q <= {1'b0, mask_q[14:8]};
        REG_CAUSE:   rdData_q <= {3'h0, cause_q};
        REG_WINNER:  rdData_q <= coreVec_q[7:0];
        default:     rdData_q <= 8'h00;  // unmapped and table reads
      endcase
    end
    else
      rdData_q <= 8'h00;
  end

  // table byte lanes: even address is the high byte
  assign tblWe = {regReq.wr && regReq.addr[TABLE_BIT] && !regReq.addr[0],
                  regReq.wr && regReq.addr[TABLE_BIT] && regReq.addr[0]};

  // handler table; the core fetch aliases any address onto it
  vec_table_mem #(
    .AW (6)
  ) handlerTable (
    .core_clk (core_clk),
    .rstn     (rstn),
    .we       (tblWe),
    .waddr    (regReq.addr[6:1]),
    .wdata    (regReq.wdata),
    .raddr    (coreAddr[6:1]),
    .rdata_q  (coreData_q)
  );

  // coreRd only qualifies the fetch for the core; the table reads every cycle
  logic coreRdSeen;
  assign coreRdSeen = coreRd;

  // top reset group always yields the top vector next cycle
  rstTopVec_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    topReset |=> coreVec_q == 16'hFFFE)
    else $error("top reset did not present FFFE");

  // clock monitor alone yields FFFC
  clkMonVec_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !topReset && resetSrc.clkMon |=> coreVec_q == 16'hFFFC)
    else $error("clock monitor reset vector wrong");

  // watchdog alone yields FFFA
  wdogVec_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !topReset && !resetSrc.clkMon && resetSrc.watchdog |=> coreVec_q == 16'hFFFA)
    else $error("watchdog reset vector wrong");

  // low voltage raises the system reset one cycle later
  lowVoltRst_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    resetSrc.lowVolt |=> sysReset_q && coreVec_q == VEC_RESET)
    else $error("low voltage did not reset");

  // I bit set blocks the maskable request
  ibitBlock_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    condCodeIBit |=> !irqReq_q)
    else $error("request shown while I bit set");

  // a request needs a gated source behind it
  reqNeedsSrc_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    irqReq_q |-> $past(winFound) && !$past(condCodeIBit))
    else $error("request without enabled source");

  // timer overflow wins by default order
  timOvfWin_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !resetAny && srcPend[0] && prio_q == 8'h00 |=> coreVec_q == 16'hFFDE)
    else $error("timer overflow lost default priority");

  // an elevated pending source takes the vector
  elevWin_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !resetAny && srcPend[NUM_SRC-1] && prio_q == 8'hA0 |=> coreVec_q == 16'hFFA0)
    else $error("elevated source did not win");

  // a system reset puts control registers back to start values
  softRst_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    resetAny |=> en_q == 16'h0000 && mask_q == 15'h0000 && prio_q == 8'h00)
    else $error("registers not restored by reset");

  // a pending source is never lost from status outside a system reset
  stickySet_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !resetAny |=> (stat_q & $past(srcPend)) == $past(srcPend))
    else $error("pending source missing from status");

  // a system reset is shown and hides any maskable request
  resetNoReq_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    resetAny |=> sysReset_q && !irqReq_q)
    else $error("request shown during system reset");

  // status flags go back to their start value on a system reset
  statRst_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    resetAny |=> stat_q == 15'h0000)
    else $error("status not cleared by reset");

  // nothing gated and pending means no request next cycle
  noSrcNoReq_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !winFound |=> !irqReq_q)
    else $error("request with nothing pending");

endmodule

// ---- verif/core_fetch_model.sv ----
`timescale 1ns/1ps
// core side: fetches the vector word whenever a request or a reset is shown
module core_fetch_model (
  input  logic                  core_clk,
  input  logic                  rstn,
  input  logic                  irqReq_q,
  input  logic                  sysReset_q,
  input  vec_map_pkg::vecAddr_t coreVec_q,
  input  logic [15:0]           coreData_q,
  output logic                  coreRd,
  output logic [15:0]           coreAddr,
  output logic [15:0]           fetchWord
);
  import vec_map_pkg::*;

  logic rdDly;

  // idle address is inverted every cycle so a stale vector never looks like a fetch
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      coreRd    <= 1'b0;
      coreAddr  <= 16'h0000;
      rdDly     <= 1'b0;
      fetchWord <= 16'h0000;
    end
    else
    begin
      coreRd   <= irqReq_q | sysReset_q;
      coreAddr <= (irqReq_q | sysReset_q) ? coreVec_q : ~coreAddr;
      rdDly    <= coreRd;
      // table word lands one cycle after the address
      if (rdDly)
        fetchWord <= coreData_q;
    end
  end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import vec_map_pkg::*;

  logic        core_clk     = 1'b0;
  logic        rstn         = 1'b0;
  regReq_t     regReq       = '0;
  logic [15:0] rawReq       = 16'h0000;
  logic        condCodeIBit = 1'b0;
  resetSrc_t   resetSrc     = '0;
  logic        coreRd;
  logic [15:0] coreAddr;
  logic [15:0] coreData_q;
  logic [15:0] fetchWord;
  logic [7:0]  rdData_q;
  logic        irqReq_q;
  logic        sysReset_q;
  logic        intr_q;
  vecAddr_t    coreVec_q;
  int          mismatches   = 0;
  int          nCompared    = 0;
  int          s;
  vecAddr_t    tv;
  // expected maskable vectors, by source, highest default priority first
  vecAddr_t    expVec [15]  = '{16'hFFDE, 16'hFFDC, 16'hFFDA, 16'hFFB8, 16'hFFB4,
                                16'hFFB2, 16'hFFB0, 16'hFFAE, 16'hFFAC, 16'hFFAA,
                                16'hFFA8, 16'hFFA6, 16'hFFA4, 16'hFFA2, 16'hFFA0};
  // reset source combinations and the vector each must win with
  logic [4:0]  rsCode [7]   = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h03, 5'h13};
  vecAddr_t    rsVec [7]    = '{16'hFFFE, 16'hFFFE, 16'hFFFE, 16'hFFFC, 16'hFFFA,
                                16'hFFFC, 16'hFFFE};
  vecAddr_t    tblVec [3]   = '{16'hFFFE, 16'hFFFC, 16'hFFFA};

  always #25 core_clk = ~core_clk;

  vector_and_reset_priority_map dut_u (
    .core_clk     (core_clk),
    .rstn         (rstn),
    .regReq       (regReq),
    .rdData_q     (rdData_q),
    .rawReq       (rawReq),
    .condCodeIBit (condCodeIBit),
    .resetSrc     (resetSrc),
    .coreRd       (coreRd),
    .coreAddr     (coreAddr),
    .coreData_q   (coreData_q),
    .irqReq_q     (irqReq_q),
    .coreVec_q    (coreVec_q),
    .sysReset_q   (sysReset_q),
    .intr_q       (intr_q)
  );

  core_fetch_model core_u (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .irqReq_q   (irqReq_q),
    .sysReset_q (sysReset_q),
    .coreVec_q  (coreVec_q),
    .coreData_q (coreData_q),
    .coreRd     (coreRd),
    .coreAddr   (coreAddr),
    .fetchWord  (fetchWord)
  );

  // handler word chosen so a byte swap is visible
  function automatic logic [15:0] hw(input vecAddr_t v);
    hw = {v[7:0], ~v[7:0]};
  endfunction

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    nCompared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // wait n edges, then look in the middle of the cycle
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    @(negedge core_clk);
    chk({8'h00, rdData_q}, {8'h00, e});
  endtask

  task automatic stopTest;
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    stopTest();
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    // start-up values, unmapped offset reads zero
    for (int a = 0; a < 10; a++)
      rd(8'(a), 8'h00);
    $display("test reset_values done");
    // handler table: even offset high byte, odd offset low byte
    for (int k = 0; k < 18; k++)
    begin
      tv = k < 15 ? expVec[k] : tblVec[k-15];
      wr(tv[7:0], 8'(hw(tv) >> 8));
      wr(tv[7:0] | 8'h01, 8'(hw(tv)));
    end
    // each raw line alone: gated by its enable, its vector, masked by the I bit
    for (int i = 0; i < 16; i++)
    begin
      s = (i <= 3) ? i : i - 1;
      wr(REG_EN_LO, ~8'(16'h0001 << i));
      wr(REG_EN_HI, ~8'((16'h0001 << i) >> 8));
      @(posedge core_clk) rawReq <= 16'h0001 << i;
      settle(1);
      chk({15'h0000, irqReq_q}, 16'h0000);
      wr(REG_EN_LO, 8'(16'h0001 << i));
      wr(REG_EN_HI, 8'((16'h0001 << i) >> 8));
      settle(1);
      chk({15'h0000, irqReq_q}, 16'h0001);
      chk(coreVec_q, expVec[s]);
      settle(4);
      chk(fetchWord, hw(expVec[s]));
      @(posedge core_clk) condCodeIBit <= 1'b1;
      settle(1);
      chk({15'h0000, irqReq_q}, 16'h0000);
      @(posedge core_clk) condCodeIBit <= 1'b0;
      rawReq <= 16'h0000;
    end
    $display("test source_map done");
    // sticky status, mask and summary interrupt
    rd(REG_STAT_LO, 8'hFF);
    rd(REG_STAT_HI, 8'h7F);
    settle(1);
    chk({15'h0000, intr_q}, 16'h0000);
    wr(REG_MASK_LO, 8'h01);
    settle(1);
    chk({15'h0000, intr_q}, 16'h0001);
    wr(REG_STAT_LO, 8'hFF);
    wr(REG_STAT_HI, 8'h7F);
    settle(1);
    chk({15'h0000, intr_q}, 16'h0000);
    rd(REG_STAT_LO, 8'h00);
    // upper mask half holds seven bits, the top bit reads zero
    wr(REG_MASK_HI, 8'hFF);
    rd(REG_MASK_HI, 8'h7F);
    $display("test status_mask done");
    // all pending: default order, then elevation
    wr(REG_EN_LO, 8'hFF);
    wr(REG_EN_HI, 8'hFF);
    @(posedge core_clk) rawReq <= 16'hFFFF;
    settle(1);
    chk(coreVec_q, 16'hFFDE);
    wr(REG_PRIO, 8'hA0);
    settle(1);
    chk(coreVec_q, 16'hFFA0);
    wr(REG_PRIO, 8'hB8);
    rd(REG_WINNER, 8'hB8);
    wr(REG_PRIO, 8'h00);
    @(posedge core_clk) rawReq <= 16'hFFFE;
    settle(1);
    chk(coreVec_q, 16'hFFDC);
    $display("test priority done");
    // rstn reset mid-run: registers back to start, table must survive
    @(posedge core_clk) rstn <= 1'b0;
    settle(2);
    chk(coreVec_q, 16'hFFFE);
    @(posedge core_clk) rstn <= 1'b1;
    rd(REG_EN_LO, 8'h00);
    rd(REG_PRIO, 8'h00);
    // system reset sources, alone and together
    for (int k = 0; k < 7; k++)
    begin
      wr(REG_EN_LO, 8'hFF);
      @(posedge core_clk) resetSrc <= rsCode[k];
      settle(1);
      chk({15'h0000, sysReset_q}, 16'h0001);
      chk(coreVec_q, rsVec[k]);
      chk({15'h0000, irqReq_q}, 16'h0000);
      wr(REG_EN_LO, 8'h55);
      settle(3);
      chk(fetchWord, hw(rsVec[k]));
      @(posedge core_clk) resetSrc <= '0;
      settle(1);
      rd(REG_EN_LO, 8'h00);
      rd(REG_CAUSE, {3'h0, rsCode[k]});
      wr(REG_CAUSE, 8'h1F);
    end
    $display("test reset_sources done");
    stopTest();
  end
endmodule
